// ==== logic/ofb_top.sv ====
// Option-field bit allocator with AXI4-Lite register access
`timescale 1ns/1ns

module ofb_top
    import ofb_pkg::*;
#(
    parameter int FIELD_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [OFB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [OFB_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [FIELD_W-1:0] option_field,
    input wire logic option_valid,
    output ofb_decoded_type decoded,
    output logic decoded_valid
);

    // Register index of an address, or OFB_NUM_WORDS when not a stored word
    function automatic int alloc_index(input logic [OFB_ADDR_W-1:0] a);
        int idx;
        idx = OFB_NUM_WORDS;
        case (a)
            OFB_OFS_ALLOC2: idx = 0;
            OFB_OFS_ALLOC3: idx = 1;
            OFB_OFS_ALLOC4: idx = 2;
            OFB_OFS_ALLOC5: idx = 3;
            default: idx = OFB_NUM_WORDS;
        endcase
        return idx;
    endfunction

    // Map of one function from a word: position and enable digits
    function automatic ofb_map_type to_map(
        input logic [15:0] word,
        input int pos_sh,
        input int en_sh
    );
        ofb_map_type m;
        m.pos = word[pos_sh +: 4];
        m.en = (word[en_sh +: 4] == OFB_EN_CODE);
        return m;
    endfunction

    // Byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0] : old[7:0]};
    endfunction

    localparam logic [15:0] RST_WORDS [OFB_NUM_WORDS] = '{
        OFB_RST_ALLOC2, OFB_RST_ALLOC3, OFB_RST_ALLOC4, OFB_RST_ALLOC5
    };

    // Stored (pending) and active allocation words
    logic [15:0] stored_r [OFB_NUM_WORDS];
    logic [15:0] active_r [OFB_NUM_WORDS];
    logic load_pending_r;
    logic restart_r;
    // Write channel state
    ofb_wr_state_type wr_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [OFB_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    // Read channel state
    ofb_rd_state_type rd_state_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // Decoded outputs
    ofb_decoded_type decoded_r;
    logic decoded_valid_r;
    logic [15:0] cmd_count_r;
    // Write path
    wire aw_take = s_axi_awvalid & awready_r;
    wire w_take = s_axi_wvalid & wready_r;
    wire aw_held_nxt = aw_held_r | aw_take;
    wire w_held_nxt = w_held_r | w_take;
    wire do_write = (wr_state_r == OFB_WR_COLLECT) & aw_held_r & w_held_r;
    wire b_done = bvalid_r & s_axi_bready;
    wire [2:0] wr_idx = 3'(alloc_index(aw_addr_r));
    wire wr_is_alloc = (wr_idx < 3'(OFB_NUM_WORDS));
    wire wr_is_restart = (aw_addr_r == OFB_OFS_RESTART);
    wire wr_ok = wr_is_alloc | wr_is_restart;
    wire restart_req = do_write & wr_is_restart & w_strb_r[0] & w_data_r[0];
    // Read path
    wire ar_take = s_axi_arvalid & arready_r;
    wire r_done = rvalid_r & s_axi_rready;
    wire [2:0] rd_idx = 3'(alloc_index(s_axi_araddr));
    wire rd_is_alloc = (rd_idx < 3'(OFB_NUM_WORDS));
    wire [OFB_ADDR_W-1:0] act_ofs = s_axi_araddr - OFB_OFS_ACTIVE0;
    wire rd_is_active = (s_axi_araddr >= OFB_OFS_ACTIVE0) &
        (act_ofs[1:0] == 2'h0) & (act_ofs[OFB_ADDR_W-1:2] < OFB_NUM_WORDS);
    wire [1:0] act_idx = act_ofs[3:2];
    wire rd_is_status = (s_axi_araddr == OFB_OFS_STATUS);
    wire rd_is_count = (s_axi_araddr == OFB_OFS_COUNT);
    wire rd_is_restart = (s_axi_araddr == OFB_OFS_RESTART);
    wire rd_ok = rd_is_alloc | rd_is_active | rd_is_status | rd_is_count |
        rd_is_restart;
    wire [31:0] status_word = {{(32 - $bits(ofb_decoded_type)){1'b0}},
        decoded_r};
    wire [31:0] rd_data_nxt =
        rd_is_alloc ? {16'h0000, stored_r[rd_idx[1:0]]} :
        rd_is_active ? {16'h0000, active_r[act_idx]} :
        rd_is_status ? status_word :
        rd_is_count ? {16'h0000, cmd_count_r} :
        32'h0000_0000;
    // Function maps from the active words
    wire ofb_map_type map_speed =
        to_map(active_r[0], OFB_POS_LO, OFB_EN_LO);
    wire ofb_map_type map_fwd =
        to_map(active_r[1], OFB_POS_LO, OFB_EN_LO);
    wire ofb_map_type map_rev =
        to_map(active_r[1], OFB_POS_HI, OFB_EN_HI);
    wire ofb_map_type map_bank =
        to_map(active_r[2], OFB_POS_LO, OFB_EN_LO);
    wire ofb_map_type map_latch =
        to_map(active_r[2], OFB_POS_HI, OFB_EN_HI);
    wire ofb_map_type map_out =
        to_map(active_r[3], OFB_POS_HI, OFB_EN_HI);

    wire ofb_decoded_type dec_nxt;
    wire speed_bit;
    wire fwd_bit;
    wire rev_bit;
    wire latch_bit;
    wire [OFB_BANK_W-1:0] bank_grp;
    wire bank_act;
    wire [OFB_OUT_W-1:0] out_grp;
    wire out_act;

    ofb_bit_pick #(.FIELD_W(FIELD_W)) u_speed (
        .field(option_field),
        .map(map_speed),
        .bit_out(speed_bit)
    );
    ofb_bit_pick #(.FIELD_W(FIELD_W)) u_fwd (
        .field(option_field),
        .map(map_fwd),
        .bit_out(fwd_bit)
    );
    ofb_bit_pick #(.FIELD_W(FIELD_W)) u_rev (
        .field(option_field),
        .map(map_rev),
        .bit_out(rev_bit)
    );
    ofb_bit_pick #(.FIELD_W(FIELD_W)) u_latch (
        .field(option_field),
        .map(map_latch),
        .bit_out(latch_bit)
    );
    ofb_group_pick #(
        .FIELD_W(FIELD_W),
        .GROUP_W(OFB_BANK_W),
        .MAX_START(OFB_BANK_MAX)
    ) u_bank (
        .field(option_field),
        .map(map_bank),
        .group(bank_grp),
        .active(bank_act)
    );
    ofb_group_pick #(
        .FIELD_W(FIELD_W),
        .GROUP_W(OFB_OUT_W),
        .MAX_START(OFB_OUT_MAX)
    ) u_out (
        .field(option_field),
        .map(map_out),
        .group(out_grp),
        .active(out_act)
    );

    assign dec_nxt.speed_loop_prop_switch = speed_bit;
    assign dec_nxt.forward_torque_limit_sel = fwd_bit;
    assign dec_nxt.reverse_torque_limit_sel = rev_bit;
    assign dec_nxt.bank_selector = bank_grp;
    assign dec_nxt.bank_valid = bank_act;
    assign dec_nxt.latch_disable = latch_bit;
    assign dec_nxt.out_signal = out_grp;
    assign dec_nxt.out_valid = out_act;

    // Stored words: software writes land here only
    generate
        for (genvar i = 0; i < OFB_NUM_WORDS; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    stored_r[i] <= RST_WORDS[i];
                end else if (do_write && wr_is_alloc &&
                             wr_idx == 3'(i)) begin
                    stored_r[i] <= merge(stored_r[i], w_data_r, w_strb_r);
                end
            end

            // Active words change only at reset or a restart
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    active_r[i] <= RST_WORDS[i];
                end else if (load_pending_r || restart_r) begin
                    active_r[i] <= stored_r[i];
                end
            end
        end
    endgenerate

    // One load after reset release, one per restart request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            load_pending_r <= 1'b1;
            restart_r <= 1'b0;
        end else begin
            load_pending_r <= 1'b0;
            restart_r <= restart_req;
        end
    end

    // Write channel
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_state_r <= OFB_WR_COLLECT;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= OFB_RESP_OKAY;
        end else begin
            case (wr_state_r)
                OFB_WR_COLLECT: begin
                    if (aw_take) begin
                        aw_addr_r <= s_axi_awaddr;
                    end
                    if (w_take) begin
                        w_data_r <= s_axi_wdata;
                        w_strb_r <= s_axi_wstrb;
                    end
                    if (do_write) begin
                        wr_state_r <= OFB_WR_RESP;
                        aw_held_r <= 1'b0;
                        w_held_r <= 1'b0;
                        awready_r <= 1'b0;
                        wready_r <= 1'b0;
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_ok ? OFB_RESP_OKAY : OFB_RESP_SLVERR;
                    end else begin
                        aw_held_r <= aw_held_nxt;
                        w_held_r <= w_held_nxt;
                        awready_r <= ~aw_held_nxt;
                        wready_r <= ~w_held_nxt;
                    end
                end
                OFB_WR_RESP: begin
                    if (b_done) begin
                        wr_state_r <= OFB_WR_COLLECT;
                        bvalid_r <= 1'b0;
                        awready_r <= 1'b1;
                        wready_r <= 1'b1;
                    end
                end
                default: begin
                    wr_state_r <= OFB_WR_COLLECT;
                end
            endcase
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_state_r <= OFB_RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= OFB_RESP_OKAY;
        end else begin
            case (rd_state_r)
                OFB_RD_IDLE: begin
                    arready_r <= ~ar_take;
                    if (ar_take) begin
                        rd_state_r <= OFB_RD_DATA;
                        rvalid_r <= 1'b1;
                        rdata_r <= rd_data_nxt;
                        rresp_r <= rd_ok ? OFB_RESP_OKAY : OFB_RESP_SLVERR;
                    end
                end
                OFB_RD_DATA: begin
                    if (r_done) begin
                        rd_state_r <= OFB_RD_IDLE;
                        rvalid_r <= 1'b0;
                        arready_r <= 1'b1;
                    end
                end
                default: begin
                    rd_state_r <= OFB_RD_IDLE;
                end
            endcase
        end
    end

    // Decoded command fields, held until the next command
    always_ff @(posedge clk) begin
        if (!rstn) begin
            decoded_r <= '0;
            decoded_valid_r <= 1'b0;
            cmd_count_r <= 16'h0000;
        end else begin
            decoded_valid_r <= option_valid;
            if (option_valid) begin
                decoded_r <= dec_nxt;
                cmd_count_r <= cmd_count_r + 16'h0001;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign decoded = decoded_r;
    assign decoded_valid = decoded_valid_r;

endmodule

// ==== logic/ofb_pkg.sv ====
// Package: register map, field layout and types of the option-field allocator
package ofb_pkg;

    localparam int OFB_ADDR_W = 8;
    localparam int OFB_WORD_W = 16;
    localparam int OFB_NUM_WORDS = 4;

    localparam logic [7:0] OFB_OFS_ALLOC2 = 8'h00;
    localparam logic [7:0] OFB_OFS_ALLOC3 = 8'h04;
    localparam logic [7:0] OFB_OFS_ALLOC4 = 8'h08;
    localparam logic [7:0] OFB_OFS_ALLOC5 = 8'h0C;
    localparam logic [7:0] OFB_OFS_STATUS = 8'h10;
    localparam logic [7:0] OFB_OFS_COUNT = 8'h14;
    localparam logic [7:0] OFB_OFS_RESTART = 8'h18;
    localparam logic [7:0] OFB_OFS_ACTIVE0 = 8'h20;

    localparam logic [15:0] OFB_RST_ALLOC2 = 16'h1D1C;
    localparam logic [15:0] OFB_RST_ALLOC3 = 16'h1F1E;
    localparam logic [15:0] OFB_RST_ALLOC4 = 16'h0000;
    localparam logic [15:0] OFB_RST_ALLOC5 = 16'h0000;

    localparam int OFB_POS_LO = 0;
    localparam int OFB_EN_LO = 4;
    localparam int OFB_POS_HI = 8;
    localparam int OFB_EN_HI = 12;
    localparam logic [3:0] OFB_EN_CODE = 4'h1;

    localparam int OFB_BANK_W = 4;
    localparam logic [3:0] OFB_BANK_MAX = 4'hC;
    localparam int OFB_OUT_W = 3;
    localparam logic [3:0] OFB_OUT_MAX = 4'hD;
    localparam logic [3:0] OFB_BIT_MAX = 4'hF;

    localparam logic [1:0] OFB_RESP_OKAY = 2'h0;
    localparam logic [1:0] OFB_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] pos;
        logic en;
    } ofb_map_type;

    typedef struct packed {
        logic speed_loop_prop_switch;
        logic forward_torque_limit_sel;
        logic reverse_torque_limit_sel;
        logic [3:0] bank_selector;
        logic bank_valid;
        logic latch_disable;
        logic [2:0] out_signal;
        logic out_valid;
    } ofb_decoded_type;

    typedef enum {OFB_WR_COLLECT, OFB_WR_RESP} ofb_wr_state_type;
    typedef enum {OFB_RD_IDLE, OFB_RD_DATA} ofb_rd_state_type;

endpackage

// ==== logic/ofb_bit_pick.sv ====
// Single option bit picked by a position digit, gated by its enable
`timescale 1ns/1ns
module ofb_bit_pick
    import ofb_pkg::*;
#(
    parameter int FIELD_W = 16
) (
    input wire logic [FIELD_W-1:0] field,
    input wire ofb_map_type map,
    output logic bit_out
);
    // Disabled allocation forces the function inactive
    assign bit_out = map.en & field[map.pos];
endmodule

// ==== logic/ofb_group_pick.sv ====
// Contiguous option-bit group starting at a position digit
`timescale 1ns/1ns
module ofb_group_pick
    import ofb_pkg::*;
#(
    parameter int FIELD_W = 16,
    parameter int GROUP_W = 4,
    parameter logic [3:0] MAX_START = 4'hC
) (
    input wire logic [FIELD_W-1:0] field,
    input wire ofb_map_type map,
    output logic [GROUP_W-1:0] group,
    output logic active
);
    logic [FIELD_W-1:0] shifted;

    // Starts beyond the top setting are treated as unallocated
    assign active = map.en & (map.pos <= MAX_START);
    assign shifted = field >> map.pos;
    assign group = active ? shifted[GROUP_W-1:0] : '0;
endmodule

// ==== dv/ofb_top_sva.sv ====
// Assertions on the decode outputs of the option-field allocator
`timescale 1ns/1ns
module ofb_top_sva
    import ofb_pkg::*;
#(
    parameter int FIELD_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [OFB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [FIELD_W-1:0] option_field,
    input wire logic option_valid,
    input wire ofb_decoded_type decoded,
    input wire logic decoded_valid
);
    logic dflt_r;
    wire restart_hit = s_axi_awvalid && s_axi_awready
        && s_axi_awaddr == OFB_OFS_RESTART;

    // Mapping is known to be the reset one until a restart is written
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dflt_r <= 1'b1;
        end else if (restart_hit) begin
            dflt_r <= 1'b0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_strobe;
        option_valid |=> decoded_valid;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("decoded_valid missing after a strobe");
    property p_quiet;
        !option_valid |=> !decoded_valid && $stable(decoded);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("decode changed without a strobe");
    property p_speed;
        option_valid && dflt_r |=>
            decoded.speed_loop_prop_switch == $past(option_field[12]);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed switch not taken from bit 12");
    property p_fwd;
        option_valid && dflt_r |=>
            decoded.forward_torque_limit_sel == $past(option_field[14]);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward select not taken from bit 14");
    property p_rev;
        option_valid && dflt_r |=>
            decoded.reverse_torque_limit_sel == $past(option_field[15]);
    endproperty
    a_rev: assert property (p_rev)
        else $error("reverse select not taken from bit 15");
    property p_bank_off;
        option_valid && dflt_r |=> !decoded.bank_valid;
    endproperty
    a_bank_off: assert property (p_bank_off)
        else $error("bank selector valid while disabled");
    property p_latch_off;
        option_valid && dflt_r |=> !decoded.latch_disable;
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("latch disable set while disabled");
    property p_bank_grp;
        !decoded.bank_valid |-> decoded.bank_selector == 4'h0;
    endproperty
    a_bank_grp: assert property (p_bank_grp)
        else $error("bank group not zero while invalid");
    property p_out_grp;
        !decoded.out_valid |-> decoded.out_signal == 3'h0;
    endproperty
    a_out_grp: assert property (p_out_grp)
        else $error("output group not zero while invalid");
endmodule

bind ofb_top ofb_top_sva #(.FIELD_W(FIELD_W)) ofb_top_sva_i (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .option_field(option_field), .option_valid(option_valid),
    .decoded(decoded), .decoded_valid(decoded_valid)
);

// ==== dv/ofb_host.sv ====
// Host controller model that issues option fields of motion commands
`timescale 1ns/1ns
module ofb_host (
    input wire logic clk,
    output logic [15:0] option_field,
    output logic option_valid
);
    initial begin
        option_field = 16'h0000;
        option_valid = 1'b0;
    end
    // One command per call, back to back when called in a row
    task automatic issue(input logic [15:0] f);
        @(posedge clk);
        option_field <= f;
        option_valid <= 1'b1;
    endtask
    // Outside commands the field holds no valid data
    task automatic idle();
        @(posedge clk);
        option_valid <= 1'b0;
        option_field <= ~option_field;
    endtask
endmodule

// ==== dv/ofb_top_tb_top.sv ====
// Testbench of the option-field bit allocator
`timescale 1ns/1ns
`define CHK(n, e, g) \
    checks++; \
    if ((g) !== (e)) begin \
        $display("[ERR] %s exp %h got %h", n, e, g); \
        error_cnt++; \
    end
module ofb_top_tb_top;
    import ofb_pkg::*;
    typedef struct {
        logic [15:0] a2, a3, a4, a5, f;
        ofb_decoded_type e;
    } ofb_row_type;
    ofb_row_type rows[5] = '{
        '{16'h1D1C, 16'h1F1E, 16'h0000, 16'h0000, 16'hD000, 13'h1C00},
        '{16'h0010, 16'h0F13, 16'h151C, 16'h1D00, 16'hB029, 13'h1AFB},
        '{16'h0020, 16'h1010, 16'h001D, 16'h1E00, 16'hFFFF, 13'h0C00},
        '{16'h0011, 16'h1E1F, 16'h1F10, 16'h1000, 16'h8006, 13'h19BD},
        '{16'h0000, 16'h0000, 16'h0000, 16'h0D00, 16'hFFFF, 13'h0000}
    };
    logic [15:0] rst_w[4] = '{16'h1D1C, 16'h1F1E, 16'h0000, 16'h0000};
    ofb_row_type r;
    logic clk;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, dvalid, ovalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [15:0] ofield;
    ofb_decoded_type decoded;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    ofb_top ofb_top_i (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .option_field(ofield),
        .option_valid(ovalid), .decoded(decoded), .decoded_valid(dvalid)
    );
    ofb_host ofb_host_i (.clk(clk), .option_field(ofield),
        .option_valid(ovalid));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic cmd(input logic [15:0] f, input ofb_decoded_type e);
        ofb_host_i.issue(f);
        ofb_host_i.idle();
        #1;
        `CHK("decoded_valid", 1'b1, dvalid)
        `CHK("decoded", e, decoded)
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rdr(OFB_OFS_ALLOC2 + 8'(4 * i));
            `CHK("reset word", {16'h0000, rst_w[i]}, rd)
        end
        ofb_host_i.issue(16'h4000);
        ofb_host_i.issue(16'h9000);
        #1;
        `CHK("decoded", 13'h0800, decoded)
        ofb_host_i.idle();
        #1;
        `CHK("decoded", 13'h1400, decoded)
        repeat (3) @(posedge clk);
        #1;
        `CHK("decoded_valid", 1'b0, dvalid)
        `CHK("decoded", 13'h1400, decoded)
        wr(8'h1C, 16'h0001);
        `CHK("bresp", OFB_RESP_SLVERR, resp)
        wr(OFB_OFS_STATUS, 16'h0001);
        `CHK("bresp", OFB_RESP_SLVERR, resp)
        rdr(8'h1C);
        `CHK("rresp", OFB_RESP_SLVERR, resp)
        `CHK("rdata", 32'h0, rd)
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            wr(OFB_OFS_ALLOC2, r.a2);
            wr(OFB_OFS_ALLOC3, r.a3);
            wr(OFB_OFS_ALLOC4, r.a4);
            wr(OFB_OFS_ALLOC5, r.a5);
            wr(OFB_OFS_RESTART, 16'h0001);
            `CHK("bresp", OFB_RESP_OKAY, resp)
            repeat (3) @(posedge clk);
            rdr(OFB_OFS_ACTIVE0 + 8'h0C);
            `CHK("active word", {16'h0000, r.a5}, rd)
            cmd(r.f, r.e);
        end
        wr(OFB_OFS_ALLOC2, 16'h0010);
        `CHK("bresp", OFB_RESP_OKAY, resp)
        wr(OFB_OFS_RESTART, 16'h0000);
        `CHK("bresp", OFB_RESP_OKAY, resp)
        repeat (3) @(posedge clk);
        cmd(16'h0001, 13'h0000);
        rdr(OFB_OFS_ALLOC2);
        `CHK("pending word", 32'h0010, rd)
        rdr(OFB_OFS_ACTIVE0);
        `CHK("active word", 32'h0, rd)
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        cmd(16'hD000, 13'h1C00);
        rdr(OFB_OFS_STATUS);
        `CHK("status", 32'h0000_1C00, rd)
        rdr(OFB_OFS_COUNT);
        `CHK("count", 32'h0000_0001, rd)
        stop_test();
    end
endmodule
